// ==== hw/nvr_consts.svh ====
`ifndef NVR_CONSTS_SVH
`define NVR_CONSTS_SVH

// Array geometry
`define NVR_DEPTH 131072
`define NVR_ADDR_TOP 17'h1FFFF
`define NVR_ADDR_ONE 17'h00001

// Bus byte codes
`define NVR_TYPE_CODE 4'hA
`define NVR_ID_ADDR 7'h7C
`define NVR_HS_CODE 5'h01
`define NVR_SLEEP_CMD 8'h86

// Serial shifter
`define NVR_BITS 4'h8
`define NVR_BIT_ONE 4'h1
`define NVR_BIT_ZERO 4'h0

// Byte position within a transfer
`define NVR_IDX_HDR 2'h0
`define NVR_IDX_HI 2'h1
`define NVR_IDX_LO 2'h2
`define NVR_IDX_DATA 2'h3

// Identity stream: three identity bytes then eight serial bytes
`define NVR_ID_LAST 4'hA
`define NVR_ID_ZERO 4'h0
`define NVR_ID_ONE 4'h1

// Pin filter reset: clock and data idle high, straps low
`define NVR_PIN_RST 5'h18
`define NVR_LINE_IDLE 1'b1

// Buffer fill level
`define NVR_FIFO_FULL 2'h2
`define NVR_FIFO_EMPTY 2'h0
`define NVR_FIFO_ONE 2'h1

// Register byte addresses
`define NVR_REG_CTRL 8'h00
`define NVR_REG_STATUS 8'h04
`define NVR_REG_ADDR 8'h08
`define NVR_REG_ID 8'h0C
`define NVR_REG_SER_LO 8'h10
`define NVR_REG_SER_HI 8'h14

// Control bits
`define NVR_CTRL_WAKE 0
`define NVR_CTRL_HOLD 1

`endif

// ==== hw/nvr_pkg.sv ====
package nvr_pkg;

  typedef enum logic [2:0] {
    nvr_st_idle = 3'h0,
    nvr_st_recv = 3'h1,
    nvr_st_sack = 3'h3,
    nvr_st_send = 3'h2,
    nvr_st_mack = 3'h6
  } nvr_state_e;

  typedef enum logic [1:0] {
    nvr_acc_none = 2'h0,
    nvr_acc_mem = 2'h1,
    nvr_acc_id = 2'h2
  } nvr_acc_e;

  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] data;
  } nvr_wr_s;

  typedef struct packed {
    nvr_wr_s [1:0] ent;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } nvr_fifo_s;

  typedef struct packed {
    nvr_state_e state;
    nvr_acc_e acc;
    logic rw;
    logic [1:0] idx;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [16:0] addr;
    logic [3:0] id_ptr;
    logic macked;
    logic sleep;
    logic hs;
    logic hold;
    logic sda_oe;
    logic sda_o;
    logic ack;
    logic [31:0] dat;
    logic scl_p;
    logic sda_p;
  } nvr_core_s;

endpackage

// ==== hw/nvr_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module nvr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } nvr_sync_s;

  nvr_sync_s q, d;

  // A bit moves only once the second and third stages agree
  always_comb begin
    d = q;
    d.s1 = d_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.q[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= {RST, RST, RST, RST};
    end else begin
      q <= d;
    end
  end

  assign q_o = q.q;

endmodule

`default_nettype wire

// ==== hw/nvr_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nvr_consts.svh"

module nvr_fifo (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire nvr_pkg::nvr_wr_s in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output nvr_pkg::nvr_wr_s out_data_o
);

  nvr_pkg::nvr_fifo_s q, d;
  logic push, pop;

  assign in_ready_o = (q.cnt != `NVR_FIFO_FULL);
  assign out_valid_o = (q.cnt != `NVR_FIFO_EMPTY);
  assign out_data_o = q.ent[q.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.ent[q.wp] = in_data_i;
      d.wp = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    case ({push, pop})
      2'h2: d.cnt = q.cnt + `NVR_FIFO_ONE;
      2'h1: d.cnt = q.cnt - `NVR_FIFO_ONE;
      default: d.cnt = q.cnt;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
    q.cnt <= `NVR_FIFO_FULL)
    else $error("buffer count beyond two entries");

endmodule

`default_nettype wire

// ==== hw/nvr_i2c_slave.sv ====
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "nvr_consts.svh"

module nvr_i2c_slave #(
  // Arbitrary identity and serial values
  parameter logic [23:0] DEV_ID = 24'h123456,
  parameter logic [63:0] SERIAL = 64'h0011223344556677
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic wp_i,
  input wire logic [1:0] device_select_pins_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin filtering and bus events

  nvr_pkg::nvr_core_s q, d;
  logic [4:0] pins;
  logic scl, sda, wp;
  logic [1:0] sel;
  logic rise, fall, start, stop;

  // Filter bounds rate
  // Answers come five clocks after a clock fall, so each low phase must outlast that
  nvr_sync #(
    .W(5),
    .RST(`NVR_PIN_RST)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({scl_i, sda_i, wp_i, device_select_pins_i}),
    .q_o(pins)
  );

  assign scl = pins[4];
  assign sda = pins[3];
  assign wp = pins[2];
  assign sel = pins[1:0];

  // Clock and data share the filter, so START and STOP keep their order
  assign rise = scl & ~q.scl_p;
  assign fall = ~scl & q.scl_p;
  assign start = q.sda_p & ~sda & scl & q.scl_p;
  assign stop = ~q.sda_p & sda & scl & q.scl_p;

  ////////////////////////////////////////////////////////////////////////////
  // Write buffer and array

  nvr_pkg::nvr_wr_s push_data, pop_data;
  logic push, push_rdy, pop_v, pop_r;
  logic [7:0] rd_byte, nxt_byte;
  logic [87:0] id_vec;
  logic [7:0] mem [`NVR_DEPTH];

  nvr_fifo u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(push_rdy),
    .in_data_i(push_data),
    .out_valid_o(pop_v),
    .out_ready_i(pop_r),
    .out_data_o(pop_data)
  );

  // Software may freeze commits; a full buffer then refuses further bytes
  assign pop_r = ~q.hold;

  always_ff @(posedge clk_i) begin
    if (pop_v & pop_r) begin
      mem[pop_data.addr] <= pop_data.data;
    end
  end

  assign rd_byte = mem[q.addr];
  assign id_vec = {DEV_ID, SERIAL};
  assign nxt_byte = (q.acc == nvr_pkg::nvr_acc_id) ? id_vec[8'd87 - {q.id_ptr, 3'h0} -: 8] : rd_byte;
  assign push_data = '{addr: q.addr, data: q.shreg};

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.scl_p = scl;
    d.sda_p = sda;
    d.ack = 1'b0;
    push = 1'b0;

    if (wb_cyc_i & wb_stb_i & ~q.ack) begin
      d.ack = 1'b1;
      case (wb_adr_i)
        `NVR_REG_CTRL: begin
          if (wb_we_i & wb_sel_i[0]) begin
            d.hold = wb_dat_i[`NVR_CTRL_HOLD];
            if (wb_dat_i[`NVR_CTRL_WAKE]) begin
              d.sleep = 1'b0;
            end
          end
          d.dat = {30'h0, q.hold, 1'b0};
        end
        `NVR_REG_STATUS: d.dat = {28'h0, wp, q.state != nvr_pkg::nvr_st_idle, q.hs, q.sleep};
        `NVR_REG_ADDR: d.dat = {15'h0, q.addr};
        `NVR_REG_ID: d.dat = {8'h0, DEV_ID};
        `NVR_REG_SER_LO: d.dat = SERIAL[31:0];
        `NVR_REG_SER_HI: d.dat = SERIAL[63:32];
        default: d.dat = 32'h0;
      endcase
    end

    if (stop) begin
      d.state = nvr_pkg::nvr_st_idle;
      d.sda_oe = 1'b0;
      d.hs = 1'b0;
    end else if (start) begin
      d.state = nvr_pkg::nvr_st_recv;
      d.bitcnt = `NVR_BIT_ZERO;
      d.idx = `NVR_IDX_HDR;
      d.acc = nvr_pkg::nvr_acc_none;
      d.sda_oe = 1'b0;
    end else begin
      case (q.state)
        nvr_pkg::nvr_st_recv: begin
          if (rise) begin
            d.shreg = {q.shreg[6:0], sda};
            d.bitcnt = q.bitcnt + `NVR_BIT_ONE;
          end else if (fall && q.bitcnt == `NVR_BITS) begin
            d.ack = q.ack;
            d.sda_oe = 1'b0;
            if (q.idx == `NVR_IDX_HDR) begin
              if (q.shreg[7:4] == `NVR_TYPE_CODE && q.shreg[3:2] == sel) begin
                if (q.sleep) begin
                  d.sleep = 1'b0;
                end else begin
                  d.sda_oe = 1'b1;
                  d.acc = nvr_pkg::nvr_acc_mem;
                  d.rw = q.shreg[0];
                  if (!q.shreg[0]) begin
                    d.addr[16] = q.shreg[1];
                  end
                end
              end else if (q.shreg[7:1] == `NVR_ID_ADDR && !q.sleep) begin
                d.sda_oe = 1'b1;
                d.acc = nvr_pkg::nvr_acc_id;
                d.rw = q.shreg[0];
                d.id_ptr = `NVR_ID_ZERO;
              end else if (q.shreg[7:3] == `NVR_HS_CODE) begin
                d.hs = 1'b1;
              end
            end else if (q.acc == nvr_pkg::nvr_acc_id) begin
              if (q.idx == `NVR_IDX_HI && q.shreg == `NVR_SLEEP_CMD) begin
                d.sda_oe = 1'b1;
                d.sleep = 1'b1;
              end
            end else if (q.idx == `NVR_IDX_HI) begin
              d.sda_oe = 1'b1;
              d.addr[15:8] = q.shreg;
            end else if (q.idx == `NVR_IDX_LO) begin
              d.sda_oe = 1'b1;
              d.addr[7:0] = q.shreg;
            end else begin
              d.sda_oe = wp | push_rdy;
              push = ~wp & push_rdy;
              if (wp | push_rdy) begin
                d.addr = q.addr + `NVR_ADDR_ONE;
              end
            end
            if (d.sda_oe) begin
              d.state = nvr_pkg::nvr_st_sack;
              d.idx = (q.idx == `NVR_IDX_DATA) ? q.idx : q.idx + 2'h1;
            end else begin
              d.state = nvr_pkg::nvr_st_idle;
            end
          end
        end
        nvr_pkg::nvr_st_sack: begin
          if (fall) begin
            d.sda_oe = 1'b0;
            d.bitcnt = `NVR_BIT_ZERO;
            d.state = nvr_pkg::nvr_st_recv;
            if (q.rw) begin
              d.tx = nxt_byte;
              d.sda_oe = ~nxt_byte[7];
              d.bitcnt = `NVR_BIT_ONE;
              d.state = nvr_pkg::nvr_st_send;
              if (q.acc == nvr_pkg::nvr_acc_id) begin
                d.id_ptr = (q.id_ptr == `NVR_ID_LAST) ? `NVR_ID_ZERO : q.id_ptr + `NVR_ID_ONE;
              end else begin
                d.addr = q.addr + `NVR_ADDR_ONE;
              end
            end
          end
        end
        nvr_pkg::nvr_st_send: begin
          if (fall) begin
            if (q.bitcnt == `NVR_BITS) begin
              d.sda_oe = 1'b0;
              d.state = nvr_pkg::nvr_st_mack;
            end else begin
              d.tx = {q.tx[6:0], 1'b0};
              d.sda_oe = ~q.tx[6];
              d.bitcnt = q.bitcnt + `NVR_BIT_ONE;
            end
          end
        end
        nvr_pkg::nvr_st_mack: begin
          if (rise) begin
            d.macked = ~sda;
          end else if (fall) begin
            if (q.macked) begin
              d.tx = nxt_byte;
              d.sda_oe = ~nxt_byte[7];
              d.bitcnt = `NVR_BIT_ONE;
              d.state = nvr_pkg::nvr_st_send;
              if (q.acc == nvr_pkg::nvr_acc_id) begin
                d.id_ptr = (q.id_ptr == `NVR_ID_LAST) ? `NVR_ID_ZERO : q.id_ptr + `NVR_ID_ONE;
              end else begin
                d.addr = q.addr + `NVR_ADDR_ONE;
              end
            end else begin
              d.state = nvr_pkg::nvr_st_idle;
            end
          end
        end
        default: begin
          d.sda_oe = 1'b0;
          d.state = nvr_pkg::nvr_st_idle;
        end
      endcase
    end
    if (q.state == nvr_pkg::nvr_st_recv && fall && q.bitcnt == `NVR_BITS) begin
      d.ack = (wb_cyc_i & wb_stb_i & ~q.ack);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register and outputs

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      // Edge history starts at the idle line level, so no false edge follows reset
      q.scl_p <= `NVR_LINE_IDLE;
      q.sda_p <= `NVR_LINE_IDLE;
    end else begin
      q <= d;
    end
  end

  assign sda_o = q.sda_o;
  assign sda_oe_o = q.sda_oe;
  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_drive_low_only: assert property (!sda_o)
    else $error("data line driven high");

  a_oe_on_fall: assert property ($rose(sda_oe_o) |-> $past(fall))
    else $error("data line pulled outside a falling clock edge");

  a_idle_released: assert property (q.state == nvr_pkg::nvr_st_idle |-> !sda_oe_o)
    else $error("line held while idle");

  a_start_ready: assert property (start |=> q.state == nvr_pkg::nvr_st_recv && q.bitcnt == `NVR_BIT_ZERO)
    else $error("START not taken at once");

  a_sel_match: assert property ((q.state == nvr_pkg::nvr_st_sack && $past(q.state) == nvr_pkg::nvr_st_recv
    && q.idx == `NVR_IDX_HI && q.acc == nvr_pkg::nvr_acc_mem) |-> q.shreg[3:2] == sel && q.shreg[7:4] == `NVR_TYPE_CODE)
    else $error("header acknowledged without match");

  a_wp_no_push: assert property (wp |-> !push)
    else $error("write queued under protect");

  a_commit_lands: assert property ((pop_v && pop_r) |=> mem[$past(pop_data.addr)] == $past(pop_data.data))
    else $error("drained byte not in array");

  a_addr_wraps: assert property (($past(q.addr) == `NVR_ADDR_TOP && q.addr != $past(q.addr)) |-> q.addr == 17'h0)
    else $error("address did not wrap to zero");

  a_hs_exit: assert property (stop |=> !q.hs)
    else $error("high speed kept after STOP");

  a_sleep_taken: assert property ((q.state == nvr_pkg::nvr_st_recv && fall && q.bitcnt == `NVR_BITS
    && q.acc == nvr_pkg::nvr_acc_id && q.idx == `NVR_IDX_HI && q.shreg == `NVR_SLEEP_CMD && !start && !stop)
    |=> q.sleep && sda_oe_o)
    else $error("sleep request not taken");

  a_wb_ack_pulse: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a one-cycle pulse");

endmodule

`default_nettype wire

// ==== tb/nvr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
module nvr_host (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // Clock stands high and data is released between frames
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////
  // 800 ns clock period
  // Low phase of six cycles outlasts the slave's filtered answer, so data never moves while the clock is high
  task automatic bit_c(input logic b, output logic r);
    tick(2);
    sda_oe_o <= ~b;
    tick(4);
    scl_o <= 1'b1;
    tick(2);
    r = sda_i;
    scl_o <= 1'b0;
  endtask

  task automatic start_c();
    tick(2);
    sda_oe_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_oe_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
  endtask

  task automatic stop_c();
    tick(2);
    sda_oe_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_oe_o <= 1'b0;
    tick(4);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(b[i], r);
    end
    bit_c(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, d[i]);
    end
    bit_c(nak, r);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Arbitrary identity values
  localparam logic [23:0] ID_T = 24'h5A3C81;
  localparam logic [63:0] SER_T = 64'h0F1E2D3C4B5A6978;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp_i = 1'b0;
  logic [1:0] pins = 2'h0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic scl_w;
  logic host_oe;
  logic sda_o_w;
  logic sda_oe_w;
  wire logic sda_w;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #50 clk_i = ~clk_i;
  // Pull-up wins unless some party pulls low
  assign sda_w = (sda_oe_w ? sda_o_w : 1'b1) & ~host_oe;

  nvr_i2c_slave #(.DEV_ID(ID_T), .SERIAL(SER_T)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o_w), .sda_oe_o(sda_oe_w),
    .wp_i(wp_i), .device_select_pins_i(pins), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack)
  );
  nvr_host u_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_oe_o(host_oe));

  ////////////////////////////////////////////////////////////
  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask

  task automatic hb(input logic [7:0] b, input logic e);
    logic a;
    u_host.wr_byte(b, a);
    chk({31'h0, a}, {31'h0, e});
  endtask

  function automatic logic [7:0] hdr(input logic page, input logic rd);
    return {4'hA, pins, page, rd};
  endfunction

  task automatic setaddr(input logic [16:0] a);
    u_host.start_c();
    hb(hdr(a[16], 1'b0), 1'b1);
    hb(a[15:8], 1'b1);
    hb(a[7:0], 1'b1);
  endtask

  task automatic rdseq(input logic [7:0] h, input int n, input logic [63:0] e);
    logic [7:0] d;
    u_host.start_c();
    hb(h, 1'b1);
    for (int i = n - 1; i >= 0; i--) begin
      u_host.rd_byte(i == 0, d);
      chk({24'h0, d}, {24'h0, e[i*8 +: 8]});
    end
    u_host.stop_c();
  endtask

  task automatic rdmem(input logic [16:0] a, input int n, input logic [63:0] e);
    setaddr(a);
    u_host.stop_c();
    rdseq(hdr(1'b0, 1'b1), n, e);
  endtask

  task automatic wrone(input logic [16:0] a, input logic [7:0] d);
    setaddr(a);
    hb(d, 1'b1);
    u_host.stop_c();
  endtask

  ////////////////////////////////////////////////////////////
  task automatic s_regs();
    logic [31:0] r;
    chk({31'h0, sda_oe_w}, 32'h0);
    rreg(8'h04, 32'hF, 32'h0);
    rreg(8'h0C, 32'hFFFFFFFF, {8'h00, ID_T});
    rreg(8'h10, 32'hFFFFFFFF, SER_T[31:0]);
    rreg(8'h14, 32'hFFFFFFFF, SER_T[63:32]);
    wb(1'b1, 8'h0C, 32'hFFFFFFFF, r);
    rreg(8'h0C, 32'hFFFFFFFF, {8'h00, ID_T});
    rreg(8'h40, 32'hFFFFFFFF, 32'h0);
  endtask

  task automatic s_select();
    for (int p = 0; p < 4; p++) begin
      pins <= 2'(p);
      repeat (4) @(posedge clk_i);
      u_host.start_c();
      hb({4'hA, 2'(p + 1), 2'h0}, 1'b0);
      u_host.stop_c();
      u_host.start_c();
      hb({4'hA, 2'(p), 2'h0}, 1'b1);
      u_host.stop_c();
    end
    u_host.start_c();
    hb({4'h5, pins, 2'h0}, 1'b0);
    u_host.stop_c();
  endtask

  task automatic s_wrap();
    wrone(17'h0FFFF, 8'h44);
    setaddr(17'h1FFFF);
    hb(8'h11, 1'b1);
    hb(8'h22, 1'b1);
    hb(8'h33, 1'b1);
    u_host.stop_c();
    rdmem(17'h0FFFF, 1, 64'h44);
    rdmem(17'h1FFFF, 3, 64'h112233);
    rreg(8'h08, 32'h1FFFF, 32'h2);
  endtask

  task automatic s_wp();
    wrone(17'h00100, 8'hC3);
    wp_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rreg(8'h04, 32'h8, 32'h8);
    wrone(17'h00100, 8'h5A);
    rreg(8'h08, 32'h1FFFF, 32'h101);
    rdmem(17'h00100, 1, 64'hC3);
    wp_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wrone(17'h00100, 8'h5A);
    rdmem(17'h00100, 1, 64'h5A);
  endtask

  // Hold bit stalls the buffer until it refuses a third byte
  task automatic s_buf();
    logic [31:0] r;
    wb(1'b1, 8'h00, 32'h2, r);
    setaddr(17'h00200);
    hb(8'hA1, 1'b1);
    hb(8'hB2, 1'b1);
    hb(8'hC3, 1'b0);
    u_host.stop_c();
    wb(1'b1, 8'h00, 32'h0, r);
    rdmem(17'h00200, 2, 64'hA1B2);
  endtask

  task automatic s_sleep();
    logic [31:0] r;
    for (int k = 0; k < 2; k++) begin
      u_host.start_c();
      hb(8'hF8, 1'b1);
      hb(8'h86, 1'b1);
      rreg(8'h04, 32'h1, 32'h1);
      u_host.stop_c();
      if (k == 0) begin
        u_host.start_c();
        hb(hdr(1'b0, 1'b0), 1'b0);
        u_host.stop_c();
      end else begin
        wb(1'b1, 8'h00, 32'h1, r);
      end
      rreg(8'h04, 32'h1, 32'h0);
    end
  endtask

  task automatic s_hs();
    u_host.start_c();
    hb(8'h0B, 1'b0);
    rreg(8'h04, 32'h2, 32'h2);
    setaddr(17'h00300);
    hb(8'h5C, 1'b1);
    rreg(8'h04, 32'h2, 32'h2);
    rreg(8'h04, 32'h4, 32'h4);
    u_host.stop_c();
    rreg(8'h04, 32'h2, 32'h0);
    rdmem(17'h00300, 1, 64'h5C);
  endtask

  ////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (sda_oe_w === 1'b1 && sda_o_w !== 1'b0) begin
      err_total++;
      $display("BAD %0t data line driven high", $time);
    end
  end

  // Whole run needs about 7300 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    s_regs();
    s_select();
    s_wrap();
    s_wp();
    s_buf();
    rdseq(8'hF9, 8, {ID_T, SER_T[63:24]});
    s_sleep();
    s_hs();
    conclude();
  end
endmodule
`default_nettype wire
